// ===== ctim_cfg.svh
// Offsets, field positions, reset values and widths of the threshold and mask registers.
`ifndef CTIM_CFG_SVH
`define CTIM_CFG_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define CTIM_ADDR_W            6
`define CTIM_DATA_W            16
`define CTIM_OFF_THRESH        6'h04
`define CTIM_OFF_MASK          6'h05

// ----------------------------------------------------------------------------
// Reset values and writable bits
// ----------------------------------------------------------------------------
`define CTIM_THRESH_RST        16'h008d
`define CTIM_MASK_RST          16'h8000
`define CTIM_MASK_WR_BITS      16'h9f1f

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CTIM_LEVEL_HI          15
`define CTIM_LEVEL_LO          8
`define CTIM_OFFSET_HI         7
`define CTIM_OFFSET_LO         0
`define CTIM_BIT_ATTN          15
`define CTIM_BIT_RAM_ADDR      12
`define CTIM_BIT_ARB_BUSY      11
`define CTIM_BIT_STRM_DATA     10
`define CTIM_BIT_SYNTH_LOOP    9
`define CTIM_BIT_DEEP_DOZE     8
`define CTIM_BIT_DOZE          4
`define CTIM_BIT_CMP_FOUR      3
`define CTIM_BIT_CMP_THREE     2
`define CTIM_BIT_CMP_TWO       1
`define CTIM_BIT_CMP_ONE       0

// ----------------------------------------------------------------------------
// Interrupt sources
// ----------------------------------------------------------------------------
`define CTIM_NUM_SRC           10

`endif

// ===== ctim_pkg.sv
// Types shared by the threshold and interrupt mask register block.
package ctim_pkg;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [5:0]  addr;
        logic [15:0] wdata;
    } ctim_reg_req_type;

    typedef struct packed {
        logic       valid;
        logic [7:0] value;
    } ctim_meas_type;

    typedef enum logic [1:0] {
        CTIM_AWAKE = 2'b01,
        CTIM_DOZE  = 2'b10
    } ctim_state_type;

endpackage

// ===== ctim_regs.sv
// Threshold, gain offset and interrupt mask registers with interrupt pin and doze exit control.
//
// Summary of operation
// - Upper byte holds channel clear level, resets zero.
// - Lower byte holds gain offset, resets 0x8d.
// - Result is measurement plus half the offset.
// - Pending source with gate set drives interrupt.
// - Status read clears the pending interrupts.
// - Bit 15 gates attention, set after reset.
// - Bit 12 gates packet buffer address error.
// - Bit 11 gates packet buffer arbiter busy.
// - Bit 10 gates streaming data error.
// - Bit 9 gates synthesizer loop unlock.
// - Deep doze waits for wake, stops timers.
// - Normal doze exits on comparator two or wake.
// - Bit 4 gates doze timer flag.
// - Bits 3 to 0 gate compare flags.
// - Sixteen bit access, reads have no effect.
`include "ctim_cfg.svh"

module ctim_regs #(
    parameter int NUM_SRC = `CTIM_NUM_SRC
) (
    input  wire logic                         core_clk_i,
    input  wire logic                         rst_n_i,
    input  wire ctim_pkg::ctim_reg_req_type   reg_req_i,
    output logic [15:0]                       reg_rdata_o,
    input  wire ctim_pkg::ctim_meas_type      meas_i,
    output ctim_pkg::ctim_meas_type           result_o,
    output logic [7:0]                        channel_clear_level_o,
    input  wire logic [NUM_SRC-1:0]           src_flag_i,
    input  wire logic                         status_read_i,
    output logic                              irq_n_o,
    input  wire logic                         doze_req_i,
    input  wire logic                         timer_comparator_two_i,
    input  wire logic                         wake_req_i,
    output logic                              doze_o,
    output logic                              timer_clk_en_o
);

    // ------------------------------------------------------------------------
    // Source gate selection
    // ------------------------------------------------------------------------
    // Source order: 0..3 compare one..four, 4 doze, 5 synth loop,
    // 6 streaming data, 7 arbiter busy, 8 address error, 9 attention.
    function automatic logic [NUM_SRC-1:0] gate_of(input logic [15:0] m);
        logic [NUM_SRC-1:0] g;
        g    = '0;
        g[0] = m[`CTIM_BIT_CMP_ONE];
        g[1] = m[`CTIM_BIT_CMP_TWO];
        g[2] = m[`CTIM_BIT_CMP_THREE];
        g[3] = m[`CTIM_BIT_CMP_FOUR];
        g[4] = m[`CTIM_BIT_DOZE];
        g[5] = m[`CTIM_BIT_SYNTH_LOOP];
        g[6] = m[`CTIM_BIT_STRM_DATA];
        g[7] = m[`CTIM_BIT_ARB_BUSY];
        g[8] = m[`CTIM_BIT_RAM_ADDR];
        g[9] = m[`CTIM_BIT_ATTN];
        return g;
    endfunction

    logic [15:0]              thresh_reg;
    logic [15:0]              mask_reg;
    logic [15:0]              rdata_reg;
    ctim_pkg::ctim_meas_type  result_reg;
    logic [NUM_SRC-1:0]       flag_d_reg;
    logic [NUM_SRC-1:0]       pend_reg;
    logic [NUM_SRC-1:0]       pend_next;
    logic [NUM_SRC-1:0]       gate;
    logic                     irq_n_reg;
    logic                     wake_meta_reg;
    logic                     wake_sync_reg;
    ctim_pkg::ctim_state_type state_reg;
    ctim_pkg::ctim_state_type state_next;
    logic                     clk_en_reg;
    logic                     deep;
    logic                     wr_thresh;
    logic                     wr_mask;

    assign wr_thresh = reg_req_i.wr && (reg_req_i.addr == `CTIM_OFF_THRESH);
    assign wr_mask   = reg_req_i.wr && (reg_req_i.addr == `CTIM_OFF_MASK);
    assign gate      = gate_of(mask_reg);
    assign deep      = mask_reg[`CTIM_BIT_DEEP_DOZE];

    // ------------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            thresh_reg <= `CTIM_THRESH_RST;
        end else if (wr_thresh) begin
            thresh_reg <= reg_req_i.wdata;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mask_reg <= `CTIM_MASK_RST;
        end else if (wr_mask) begin
            mask_reg <= (reg_req_i.wdata & `CTIM_MASK_WR_BITS)
                      | (`CTIM_MASK_RST & ~`CTIM_MASK_WR_BITS);
        end
    end

    // ------------------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_reg <= 16'h0000;
        end else if (reg_req_i.rd) begin
            unique case (reg_req_i.addr)
                `CTIM_OFF_THRESH: rdata_reg <= thresh_reg;
                `CTIM_OFF_MASK:   rdata_reg <= mask_reg;
                default:          rdata_reg <= 16'h0000;
            endcase
        end
    end

    assign reg_rdata_o           = rdata_reg;
    assign channel_clear_level_o = thresh_reg[`CTIM_LEVEL_HI:`CTIM_LEVEL_LO];

    // ------------------------------------------------------------------------
    // Gain compensated result
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            result_reg <= '0;
        end else begin
            result_reg.valid <= meas_i.valid;
            if (meas_i.valid) begin
                result_reg.value <= meas_i.value
                    + {1'b0, thresh_reg[`CTIM_OFFSET_HI:`CTIM_OFFSET_LO+1]};
            end
        end
    end

    assign result_o = result_reg;

    // ------------------------------------------------------------------------
    // Pending interrupts and interrupt pin
    // ------------------------------------------------------------------------
    always_comb begin
        pend_next = pend_reg;
        if (status_read_i) begin
            pend_next = '0;
        end
        pend_next = pend_next | (src_flag_i & ~flag_d_reg);
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flag_d_reg <= '0;
            pend_reg   <= '0;
        end else begin
            flag_d_reg <= src_flag_i;
            pend_reg   <= pend_next;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_n_reg <= 1'b1;
        end else begin
            irq_n_reg <= ~|(pend_reg & gate);
        end
    end

    assign irq_n_o = irq_n_reg;

    // ------------------------------------------------------------------------
    // Wake pin synchroniser
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wake_meta_reg <= 1'b0;
            wake_sync_reg <= 1'b0;
        end else begin
            wake_meta_reg <= wake_req_i;
            wake_sync_reg <= wake_meta_reg;
        end
    end

    // ------------------------------------------------------------------------
    // Doze control
    // ------------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ctim_pkg::CTIM_AWAKE: begin
                if (doze_req_i) begin
                    state_next = ctim_pkg::CTIM_DOZE;
                end
            end
            ctim_pkg::CTIM_DOZE: begin
                if (wake_sync_reg) begin
                    state_next = ctim_pkg::CTIM_AWAKE;
                end else if (!deep && timer_comparator_two_i) begin
                    state_next = ctim_pkg::CTIM_AWAKE;
                end
            end
            default: state_next = ctim_pkg::CTIM_AWAKE;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= ctim_pkg::CTIM_AWAKE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            clk_en_reg <= 1'b1;
        end else begin
            clk_en_reg <= !((state_next == ctim_pkg::CTIM_DOZE) && deep);
        end
    end

    assign doze_o         = state_reg[1];
    assign timer_clk_en_o = clk_en_reg;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    sequence s_thresh_write;
        wr_thresh;
    endsequence

    sequence s_in_deep_doze;
        doze_o && deep;
    endsequence

    property p_thresh_store;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        s_thresh_write |=> thresh_reg == $past(reg_req_i.wdata);
    endproperty
    a_thresh_store: assert property (p_thresh_store)
        else $error("Threshold register did not take written value.");

    property p_result_sum;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        meas_i.valid && !wr_thresh |=> result_o.valid
            && result_o.value == 8'($past(meas_i.value) + (thresh_reg[7:0] >> 1));
    endproperty
    a_result_sum: assert property (p_result_sum)
        else $error("Compensated result differs from value plus half offset.");

    property p_irq_asserts;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        |(pend_reg & gate) |=> !irq_n_o;
    endproperty
    a_irq_asserts: assert property (p_irq_asserts)
        else $error("Gated pending source did not assert the interrupt pin.");

    property p_irq_quiet;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (pend_reg & gate) == '0 |=> irq_n_o;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet)
        else $error("Interrupt pin asserted with no gated pending source.");

    property p_read_clears;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        status_read_i && (src_flag_i & ~flag_d_reg) == '0 |=> pend_reg == '0 ##1 irq_n_o;
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("Status read did not clear the pending interrupt.");

    property p_deep_stays;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        s_in_deep_doze ##0 (!wake_sync_reg && !wr_mask) |=> doze_o ##0 !timer_clk_en_o;
    endproperty
    a_deep_stays: assert property (p_deep_stays)
        else $error("Deep doze left without wake or timer clock not stopped.");

    property p_normal_exit;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        doze_o && !deep && (timer_comparator_two_i || wake_sync_reg) |=> !doze_o;
    endproperty
    a_normal_exit: assert property (p_normal_exit)
        else $error("Normal doze not exited on comparator two or wake.");

    property p_wake_latency;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        doze_o && $rose(wake_req_i) && !doze_req_i ##1 wake_req_i
            ##1 wake_req_i && !doze_req_i |=> !doze_o;
    endproperty
    a_wake_latency: assert property (p_wake_latency)
        else $error("Wake pin did not end doze within synchroniser delay.");

    property p_read_no_effect;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        reg_req_i.rd && !reg_req_i.wr |=> $stable(mask_reg) && $stable(thresh_reg);
    endproperty
    a_read_no_effect: assert property (p_read_no_effect)
        else $error("Register read changed a stored value.");

    property p_reserved_bits;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        wr_mask |=> (mask_reg & ~`CTIM_MASK_WR_BITS) == (`CTIM_MASK_RST & ~`CTIM_MASK_WR_BITS);
    endproperty
    a_reserved_bits: assert property (p_reserved_bits)
        else $error("Reserved mask bits do not hold their reset value.");

    property p_attn_gate;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        pend_reg[9] && mask_reg[`CTIM_BIT_ATTN] |=> !irq_n_o;
    endproperty
    a_attn_gate: assert property (p_attn_gate)
        else $error("Attention source not gated by mask bit 15.");

    property p_cmp_gate;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        pend_reg[3:0] != 4'h0 && (pend_reg[NUM_SRC-1:4] == '0)
            && (pend_reg[3:0] & mask_reg[3:0]) == 4'h0 |=> irq_n_o;
    endproperty
    a_cmp_gate: assert property (p_cmp_gate)
        else $error("Ungated compare source asserted the interrupt pin.");

endmodule // ctim_regs

// ===== ctim_host_model.sv
// Host model that issues register writes and reads toward the register block.
`include "ctim_cfg.svh"
module ctim_host_model (
    input  wire logic                  core_clk_i,
    output ctim_pkg::ctim_reg_req_type reg_req_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------------
    // Register access
    // ------------------------------------------------------------------------
    initial reg_req_o = '0;

    // One full word per access; the idle bus shows the inverse of the last word.
    task automatic access(input logic w, input logic [5:0] a, input logic [15:0] d);
        @(posedge core_clk_i);
        reg_req_o <= {w, ~w, a, d};
        @(posedge core_clk_i);
        reg_req_o <= {2'b00, ~a, ~d};
    endtask

    // Reserved mask bits are written back with their reset value of zero.
    task automatic wr_mask(input logic [15:0] d);
        access(1'b1, `CTIM_OFF_MASK, d & `CTIM_MASK_WR_BITS);
    endtask

    // The level is twice the absolute threshold power in dBm.
    task automatic set_thresh(input logic [6:0] dbm_abs, input logic [7:0] off);
        access(1'b1, `CTIM_OFF_THRESH, {dbm_abs, 1'b0, off});
    endtask
endmodule // ctim_host_model

// ===== tb.sv
// Self-checking testbench for the threshold and interrupt mask register block.
`include "ctim_cfg.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------------
    logic                       core_clk_i;
    logic                       rst_n_i;
    ctim_pkg::ctim_reg_req_type reg_req;
    logic [15:0]                rdata;
    ctim_pkg::ctim_meas_type    meas;
    ctim_pkg::ctim_meas_type    result;
    logic [7:0]                 level;
    logic [9:0]                 flags;
    logic [2:0]                 ctl;
    logic                       wake;
    logic                       irq_n;
    logic                       doze;
    logic                       tmr_en;
    logic                       rd_d = 1'b0;
    logic [15:0]                exp_q[$];
    logic [31:0]                seed;
    int                         bad_count;
    int                         check_count;
    int                         cycles;
    int                         src_bit[10] = '{0, 1, 2, 3, 4, 9, 10, 11, 12, 15};

    ctim_host_model u_host (
        .core_clk_i (core_clk_i),
        .reg_req_o  (reg_req)
    );

    ctim_regs #(
        .NUM_SRC(10)
    ) u_dut (
        .core_clk_i             (core_clk_i),
        .rst_n_i                (rst_n_i),
        .reg_req_i              (reg_req),
        .reg_rdata_o            (rdata),
        .meas_i                 (meas),
        .result_o               (result),
        .channel_clear_level_o  (level),
        .src_flag_i             (flags),
        .status_read_i          (ctl[0]),
        .irq_n_o                (irq_n),
        .doze_req_i             (ctl[2]),
        .timer_comparator_two_i (ctl[1]),
        .wake_req_i             (wake),
        .doze_o                 (doze),
        .timer_clk_en_o         (tmr_en)
    );

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", n, exp, got);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask

    task automatic pulse(input int i);
        @(posedge core_clk_i);
        ctl[i] <= 1'b1;
        @(posedge core_clk_i);
        ctl[i] <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        u_host.access(1'b0, a, 16'h0000);
    endtask

    task automatic meas_run(input logic [7:0] off);
        u_host.set_thresh(7'd75, off);
        for (int k = 0; k < 6; k++) begin
            @(posedge core_clk_i);
            seed = xs(seed);
            meas <= {1'b1, seed[7:0]};
            exp_q.push_back({8'h00, seed[7:0] + {1'b0, off[7:1]}});
        end
        @(posedge core_clk_i);
        meas <= {1'b0, ~seed[7:0]};
        step(2);
    endtask

    // ------------------------------------------------------------------------
    // Output watcher and timeout
    // ------------------------------------------------------------------------
    always @(posedge core_clk_i) begin
        rd_d <= reg_req.rd;
        if (rd_d === 1'b1 || result.valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk("unexpected", 16'h0001, 16'h0000);
            end else if (rd_d === 1'b1) begin
                chk("rdata", rdata, exp_q.pop_front());
            end else begin
                chk("result", {8'h00, result.value}, exp_q.pop_front());
            end
        end
    end

    always @(posedge core_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count++;
            close_out();
        end
    end

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        rst_n_i = 1'b0;
        meas = '0;
        flags = '0;
        ctl = '0;
        wake = 1'b0;
        seed = 32'd91797;
        bad_count = 0;
        check_count = 0;
        cycles = 0;
        step(3);
        rst_n_i <= 1'b1;
        rd(`CTIM_OFF_THRESH, 16'h008d);
        rd(`CTIM_OFF_MASK, 16'h8000);
        rd(6'h06, 16'h0000);
        $display("test reset values done");
        meas_run(8'h9b);
        rd(`CTIM_OFF_THRESH, 16'h969b);
        #1 chk("level", {8'h00, level}, 16'h0096);
        seed = xs(seed);
        meas_run(seed[7:0]);
        $display("test threshold and result done");
        u_host.access(1'b1, `CTIM_OFF_MASK, 16'hffff);
        rd(`CTIM_OFF_MASK, 16'h9f1f);
        for (int i = 0; i < 10; i++) begin
            u_host.wr_mask(16'h0001 << src_bit[i]);
            @(posedge core_clk_i);
            flags[i] <= 1'b1;
            step(3);
            #1 chk("irq_on", {15'h0000, irq_n}, 16'h0000);
            rd(`CTIM_OFF_MASK, 16'h0001 << src_bit[i]);
            #1 chk("irq_held", {15'h0000, irq_n}, 16'h0000);
            pulse(0);
            step(1);
            #1 chk("irq_clr", {15'h0000, irq_n}, 16'h0001);
            @(posedge core_clk_i);
            flags[i] <= 1'b0;
            u_host.wr_mask(~(16'h0001 << src_bit[i]) & 16'hfeff);
            @(posedge core_clk_i);
            flags[i] <= 1'b1;
            step(3);
            #1 chk("irq_gated", {15'h0000, irq_n}, 16'h0001);
            pulse(0);
            @(posedge core_clk_i);
            flags[i] <= 1'b0;
        end
        $display("test interrupt gating done");
        u_host.wr_mask(16'h0100);
        pulse(2);
        #1 chk("deep_in", {14'h0000, doze, tmr_en}, 16'h0002);
        pulse(1);
        step(2);
        #1 chk("deep_tc2", {14'h0000, doze, tmr_en}, 16'h0002);
        @(posedge core_clk_i);
        wake <= 1'b1;
        step(4);
        #1 chk("deep_wake", {14'h0000, doze, tmr_en}, 16'h0001);
        @(posedge core_clk_i);
        wake <= 1'b0;
        step(3);
        u_host.wr_mask(16'h0000);
        pulse(2);
        #1 chk("doze_in", {14'h0000, doze, tmr_en}, 16'h0003);
        pulse(1);
        step(1);
        #1 chk("doze_tc2", {14'h0000, doze, tmr_en}, 16'h0001);
        pulse(2);
        #1 chk("doze_again", {14'h0000, doze, tmr_en}, 16'h0003);
        @(posedge core_clk_i);
        wake <= 1'b1;
        step(3);
        #1 chk("doze_wake", {14'h0000, doze, tmr_en}, 16'h0001);
        @(posedge core_clk_i);
        wake <= 1'b0;
        $display("test doze done");
        step(3);
        chk("queue_left", 16'(exp_q.size()), 16'h0000);
        close_out();
    end
endmodule // tb
